// *** include/iwd_pkg.sv ***
// Package with register map, field positions and counter constants of the watchdog.
`default_nettype none
package iwd_pkg;
   // Register word offsets on the plain register port.
   localparam logic [7:0]  CTL_OFFSET    = 8'h00;
   localparam logic [7:0]  STAT_OFFSET   = 8'h04;

   // Field positions inside the key and control register.
   localparam int          KEY_MSB       = 15;
   localparam int          KEY_LSB       = 12;
   localparam int          ENABLE_BIT    = 8;
   localparam int          CKSEL_BIT     = 6;
   localparam int          STDBY_FRZ_BIT = 5;
   localparam int          STOP_FRZ_BIT  = 4;
   localparam int          PSC_MSB       = 2;
   localparam int          PSC_LSB       = 0;

   // Field position of the sticky reset flag in the status register.
   localparam int          RSTFLAG_BIT   = 12;

   // Key pattern, which also reads back from the key field.
   localparam logic [3:0]  KEY_PATTERN   = 4'b1010;

   // Reset values of the control fields.
   localparam logic        ENABLE_RST    = 1'b0;
   localparam logic        CKSEL_RST     = 1'b0;
   localparam logic        FRZ_RST       = 1'b0;
   localparam logic [2:0]  PSC_RST       = 3'h0;

   // Counter start and terminal values.
   localparam logic [11:0] CNT_START     = 12'hFFF;
   localparam logic [11:0] CNT_END       = 12'h000;

   // Widths shared by the files.
   localparam int          CNT_W         = 12;
   localparam int          PSC_W         = 8;
   localparam int          ADDR_W        = 8;
   localparam int          DATA_W        = 32;
endpackage
`default_nettype wire

// *** logic/iwd_clk_sel.sv ***
// Low-speed oscillator selection and rising edge detection for the watchdog.
`default_nettype none
module iwd_clk_sel (
   input  wire logic clk_sys,
   input  wire logic reset,
   input  wire logic internalOsc,
   input  wire logic externalOsc,
   input  wire logic stopMode,
   input  wire logic standbyMode,
   input  wire logic stopClockSelect,
   output logic      selectedOsc,
   output logic      oscEdge
);
   import iwd_pkg::*;

   logic oscPrev_q;
   logic useExternal;

   // Standby forces the internal source; stop mode obeys the select bit.
   assign useExternal = stopMode & ~standbyMode & stopClockSelect;
   assign selectedOsc = useExternal ? externalOsc : internalOsc;

   // Previous level of the selected source for edge detection.
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         oscPrev_q <= 1'b0;
      end else begin
         oscPrev_q <= selectedOsc;
      end
   end

   // One bus-clock pulse per rising edge of the chosen oscillator.
   assign oscEdge = selectedOsc & ~oscPrev_q;
endmodule
`default_nettype wire

// *** logic/iwd_prescaler.sv ***
// Power-of-two prescaler that turns oscillator edges into counter ticks.
`default_nettype none
module iwd_prescaler #(
   parameter int PSC_W = 8
) (
   input  wire logic       clk_sys,
   input  wire logic       reset,
   input  wire logic       clear,
   input  wire logic       run,
   input  wire logic       oscEdge,
   input  wire logic [2:0] prescalerSelect,
   output logic            tick
);
   import iwd_pkg::*;

   logic [PSC_W-1:0] div_q;
   logic [PSC_W-1:0] div_d;
   logic [PSC_W-1:0] terminal;
   logic             step;
   logic             atEnd;

   // Code n divides by two to the power n plus one.
   assign terminal = PSC_W'((9'd2 << prescalerSelect) - 9'd1);
   assign step     = run & oscEdge;
   assign atEnd    = (div_q == terminal);
   assign tick     = step & atEnd;
   assign div_d    = clear ? '0 : (step ? (atEnd ? '0 : div_q + 1'b1) : div_q);

   // Divider state.
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         div_q <= '0;
      end else begin
         div_q <= div_d;
      end
   end
endmodule
`default_nettype wire

// *** logic/iwd_top.sv ***
// Independent watchdog: register port, down-counter and reset generation.
//
// Behaviour
// - The key field in bits 15:12 is write-only and always reads back as 1010.
// - Control bit 8 disables the watchdog at 0 and enables counting and reset at 1.
// - In stop mode control bit 6 picks the internal (0) or external (1) low-speed oscillator.
// - In standby mode the internal low-speed oscillator is used whatever bit 6 holds.
// - Control bit 5 at 1 freezes the counter during standby, at 0 it keeps running.
// - Control bit 4 at 1 freezes the counter during stop mode outside standby, at 0 it keeps running.
// - Bits 2:0 select a prescaler of /2 for 000 doubling per code up to /256 for 111.
// - On start the counter runs down from 0xFFF and asserts the watchdog reset at 0x000.
// - Every key write of 1010 reloads the counter to its start value; one made before the count reads 0x000 holds the reset off.
`default_nettype none
module iwd_top #(
   parameter int ADDR_W = iwd_pkg::ADDR_W,
   parameter int DATA_W = iwd_pkg::DATA_W,
   parameter int PSC_W  = iwd_pkg::PSC_W
) (
   input  wire logic              clk_sys,
   input  wire logic              reset,
   input  wire logic [ADDR_W-1:0] regAddr,
   input  wire logic [DATA_W-1:0] regWrData,
   input  wire logic              regWrite,
   input  wire logic              regRead,
   output logic      [DATA_W-1:0] regRdData,
   input  wire logic              internalOsc,
   input  wire logic              externalOsc,
   input  wire logic              stopMode,
   input  wire logic              standbyMode,
   output logic                   watchdogReset
);
   import iwd_pkg::*;

   // Control fields.
   logic             enable_q;
   logic             cksel_q;
   logic             stdbyFrz_q;
   logic             stopFrz_q;
   logic [2:0]       psc_q;

   // Counter, reset flag and read data.
   logic [CNT_W-1:0] cnt_q;
   logic [CNT_W-1:0] cnt_d;
   logic             rstFlag_q;
   logic [DATA_W-1:0] rdData_d;

   // Decode and datapath wires.
   logic             hitCtl;
   logic             hitStat;
   logic             ctlWrite;
   logic             keyWrite;
   logic             startNow;
   logic             frozen;
   logic             runCount;
   logic             selectedOsc;
   logic             oscEdge;
   logic             tick;
   logic             atZero;
   logic             reload;
   logic             prescClear;
   logic [15:0]      ctlView;
   logic [15:0]      statView;

   // Address decode of the two registers.
   assign hitCtl   = (regAddr == ADDR_W'(CTL_OFFSET));
   assign hitStat  = (regAddr == ADDR_W'(STAT_OFFSET));
   assign ctlWrite = regWrite & hitCtl;

   // A write carrying the key pattern reloads the counter.
   assign keyWrite = ctlWrite & (regWrData[KEY_MSB:KEY_LSB] == KEY_PATTERN);

   // Enabling from the disabled state starts a fresh count.
   assign startNow = ctlWrite & regWrData[ENABLE_BIT] & ~enable_q;

   // Either reload source restarts the count and a fresh prescaler period.
   assign reload     = keyWrite | startNow;
   assign prescClear = reload | ~enable_q;

   // Freeze while the mode and its freeze bit are both set; the stop freeze only applies outside standby.
   assign frozen   = (standbyMode & stdbyFrz_q)
                   | (stopMode & ~standbyMode & stopFrz_q);

   // The prescaler only runs for an enabled, unfrozen watchdog.
   assign runCount = enable_q & ~frozen;
   assign atZero   = (cnt_q == CNT_END);

   // Oscillator choice and its edges.
   // Changing the source while the new oscillator is high may count one extra edge.
   iwd_clk_sel u_clk_sel (
      .clk_sys         (clk_sys),
      .reset           (reset),
      .internalOsc     (internalOsc),
      .externalOsc     (externalOsc),
      .stopMode        (stopMode),
      .standbyMode     (standbyMode),
      .stopClockSelect (cksel_q),
      .selectedOsc     (selectedOsc),
      .oscEdge         (oscEdge)
   );

   // Prescaler, cleared on every reload so a fresh period follows.
   iwd_prescaler #(
      .PSC_W (PSC_W)
   ) u_prescaler (
      .clk_sys         (clk_sys),
      .reset           (reset),
      .clear           (prescClear),
      .run             (runCount),
      .oscEdge         (oscEdge),
      .prescalerSelect (psc_q),
      .tick            (tick)
   );

   // Control register; every control write stores all rw fields.
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         enable_q   <= ENABLE_RST;
         cksel_q    <= CKSEL_RST;
         stdbyFrz_q <= FRZ_RST;
         stopFrz_q  <= FRZ_RST;
         psc_q      <= PSC_RST;
      end else if (ctlWrite) begin
         enable_q   <= regWrData[ENABLE_BIT];
         cksel_q    <= regWrData[CKSEL_BIT];
         stdbyFrz_q <= regWrData[STDBY_FRZ_BIT];
         stopFrz_q  <= regWrData[STOP_FRZ_BIT];
         psc_q      <= regWrData[PSC_MSB:PSC_LSB];
      end
   end

   // Next counter value: hold at start while off, reload, or step down.
   // A count that reached zero stays there until a reload or a disable, so the request is never missed.
   always_comb begin
      cnt_d = cnt_q;
      if (~enable_q) begin
         cnt_d = CNT_START;
      end else if (reload) begin
         cnt_d = CNT_START;
      end else if (tick & ~atZero) begin
         cnt_d = cnt_q - 1'b1;
      end
   end

   // Counter state.
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         cnt_q <= CNT_START;
      end else begin
         cnt_q <= cnt_d;
      end
   end

   // Sticky reset request, held until the system reset clears it.
   // A key write at zero cannot withdraw a request that has already been raised.
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         rstFlag_q <= 1'b0;
      end else if (enable_q & atZero) begin
         rstFlag_q <= 1'b1;
      end
   end

   assign watchdogReset = rstFlag_q;

   // Read views; the key field always shows the pattern.
   assign ctlView  = {KEY_PATTERN, 3'b000, enable_q, 1'b0, cksel_q,
                      stdbyFrz_q, stopFrz_q, 1'b0, psc_q};
   assign statView = {3'b000, rstFlag_q, cnt_q};
   assign rdData_d = ~regRead ? '0
                   : hitCtl  ? DATA_W'(ctlView)
                   : hitStat ? DATA_W'(statView)
                   : '0;

   // Read data stand for one cycle after the read strobe.
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         regRdData <= '0;
      end else begin
         regRdData <= rdData_d;
      end
   end

   // Checks on the watchdog behaviour.

   a_key_readback: assert property (@(posedge clk_sys) disable iff (reset)
      regRead & hitCtl |=> regRdData[KEY_MSB:KEY_LSB] == KEY_PATTERN)
      else $error("Key field did not read back as the pattern.");

   a_off_holds_start: assert property (@(posedge clk_sys) disable iff (reset)
      ~enable_q |=> cnt_q == CNT_START && !watchdogReset || $past(rstFlag_q))
      else $error("Disabled watchdog did not hold the start value.");

   a_key_reload: assert property (@(posedge clk_sys) disable iff (reset)
      keyWrite |=> cnt_q == CNT_START)
      else $error("Key write did not reload the counter.");

   a_tick_step: assert property (@(posedge clk_sys) disable iff (reset)
      enable_q & tick & ~atZero & ~keyWrite & ~startNow
      |=> cnt_q == $past(cnt_q) - 12'h001)
      else $error("Counter did not drop by one on a tick.");

   a_no_tick_hold: assert property (@(posedge clk_sys) disable iff (reset)
      enable_q & ~tick & ~ctlWrite |=> $stable(cnt_q))
      else $error("Counter moved without a tick.");

   a_frozen_stop: assert property (@(posedge clk_sys) disable iff (reset)
      enable_q & stopMode & ~standbyMode & stopFrz_q & ~ctlWrite [*2] |-> $stable(cnt_q))
      else $error("Counter moved while frozen in stop mode.");

   a_frozen_stdby: assert property (@(posedge clk_sys) disable iff (reset)
      enable_q & standbyMode & stdbyFrz_q & ~ctlWrite [*2] |-> $stable(cnt_q))
      else $error("Counter moved while frozen in standby.");

   a_stdby_source: assert property (@(posedge clk_sys) disable iff (reset)
      standbyMode |-> selectedOsc == internalOsc)
      else $error("Standby did not use the internal oscillator.");

   a_stop_source: assert property (@(posedge clk_sys) disable iff (reset)
      stopMode & ~standbyMode & cksel_q |-> selectedOsc == externalOsc)
      else $error("Stop mode ignored the clock select bit.");

   a_zero_resets: assert property (@(posedge clk_sys) disable iff (reset)
      enable_q & atZero |=> watchdogReset ##1 watchdogReset)
      else $error("Reaching zero did not raise the reset.");

   a_no_early_reset: assert property (@(posedge clk_sys) disable iff (reset)
      $rose(watchdogReset) |-> $past(enable_q) && $past(cnt_q) == CNT_END)
      else $error("Reset raised before the counter reached zero.");

   a_psc_spacing: assert property (@(posedge clk_sys) disable iff (reset)
      tick & psc_q == 3'h1 & ~ctlWrite |-> ##1 ~tick [*3])
      else $error("Prescaler of four ticked too soon.");

   // Checks on register storage and the counter path.

   a_rddata_idle: assert property (@(posedge clk_sys) disable iff (reset)
      ~regRead |=> regRdData == '0)
      else $error("Read data did not return to zero.");

   a_stat_count: assert property (@(posedge clk_sys) disable iff (reset)
      regRead & hitStat |=> regRdData[CNT_W-1:0] == $past(cnt_q))
      else $error("Status read did not show the counter.");

   a_enable_set: assert property (@(posedge clk_sys) disable iff (reset)
      ctlWrite & regWrData[ENABLE_BIT] |=> enable_q)
      else $error("Enable bit was not stored.");

   a_enable_clear: assert property (@(posedge clk_sys) disable iff (reset)
      ctlWrite & ~regWrData[ENABLE_BIT] |=> ~enable_q)
      else $error("Enable bit was not cleared.");

   a_cksel_store: assert property (@(posedge clk_sys) disable iff (reset)
      ctlWrite & regWrData[CKSEL_BIT] |=> cksel_q)
      else $error("Clock select bit was not stored.");

   a_stop_frz_store: assert property (@(posedge clk_sys) disable iff (reset)
      ctlWrite & regWrData[STOP_FRZ_BIT] |=> stopFrz_q)
      else $error("Stop freeze bit was not stored.");

   a_stdby_frz_store: assert property (@(posedge clk_sys) disable iff (reset)
      ctlWrite & regWrData[STDBY_FRZ_BIT] |=> stdbyFrz_q)
      else $error("Standby freeze bit was not stored.");

   a_start_reload: assert property (@(posedge clk_sys) disable iff (reset)
      startNow |=> cnt_q == CNT_START)
      else $error("Starting did not load the start value.");

   a_reset_sticky: assert property (@(posedge clk_sys) disable iff (reset)
      watchdogReset |=> watchdogReset)
      else $error("Watchdog reset fell without a system reset.");

   a_off_no_tick: assert property (@(posedge clk_sys) disable iff (reset)
      ~enable_q |-> ~tick)
      else $error("Disabled watchdog produced a tick.");

   a_frozen_no_tick: assert property (@(posedge clk_sys) disable iff (reset)
      frozen |-> ~tick)
      else $error("Frozen watchdog produced a tick.");

   a_zero_holds: assert property (@(posedge clk_sys) disable iff (reset)
      enable_q & atZero & ~ctlWrite |=> atZero)
      else $error("Counter left zero without a reload.");

   // Coverage of the main scenarios.
   c_key_write: cover property (@(posedge clk_sys) disable iff (reset)
      enable_q ##1 keyWrite);

   c_timeout: cover property (@(posedge clk_sys) disable iff (reset)
      $rose(watchdogReset));

   c_stop_freeze: cover property (@(posedge clk_sys) disable iff (reset)
      enable_q & stopMode & stopFrz_q & oscEdge);

   c_stdby_run: cover property (@(posedge clk_sys) disable iff (reset)
      enable_q & standbyMode & ~stdbyFrz_q & tick);

   c_both_modes: cover property (@(posedge clk_sys) disable iff (reset)
      enable_q & standbyMode & stopMode & tick);
endmodule
`default_nettype wire

// *** tb/iwd_top_bench.sv ***
// Self-checking testbench for the independent watchdog top module.
`default_nettype none
module iwd_top_bench;
   timeunit 1ns;
   timeprecision 100ps;
   import iwd_pkg::*;

   // Mode table: [7] standby, [6] stop, [5] clock select, [4] standby freeze,
   // [3] stop freeze, [2] pulse external oscillator, [1:0] expected counter drop.
   localparam logic [7:0] MODE_CASES [13] = '{8'h02, 8'h04, 8'h42, 8'h66, 8'h60, 8'hA2, 8'hA4,
                                               8'h48, 8'h90, 8'h8A, 8'h52, 8'hE4, 8'hCA};

   logic              clk_sys;
   logic              reset;
   logic [ADDR_W-1:0] regAddr;
   logic [DATA_W-1:0] regWrData;
   logic              regWrite;
   logic              regRead;
   logic [DATA_W-1:0] regRdData;
   logic              internalOsc;
   logic              externalOsc;
   logic              stopMode;
   logic              standbyMode;
   logic              watchdogReset;
   logic [DATA_W-1:0] rdVal;
   logic [15:0]       rndWord;
   logic [7:0]        mc;
   int                nFail;
   int                totalChecks;

   iwd_top i_iwd_top (
      .clk_sys       (clk_sys),
      .reset         (reset),
      .regAddr       (regAddr),
      .regWrData     (regWrData),
      .regWrite      (regWrite),
      .regRead       (regRead),
      .regRdData     (regRdData),
      .internalOsc   (internalOsc),
      .externalOsc   (externalOsc),
      .stopMode      (stopMode),
      .standbyMode   (standbyMode),
      .watchdogReset (watchdogReset)
   );

   // Free-running 250 MHz system clock.
   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end

   // Expected read-back of the control word: key field always reads the pattern.
   function automatic logic [31:0] exp_ctrl(input logic [15:0] w);
      return {16'h0000, KEY_PATTERN, 12'h000} | {16'h0000, w & 16'h0177};
   endfunction

   // Prints the counts and the verdict, then ends the run.
   task automatic stop_test();
      $display("checks %0d mismatches %0d", totalChecks, nFail);
      if (nFail == 0 && totalChecks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // Compares a register word.
   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
      totalChecks++;
      if (got !== exp) begin
         nFail++;
         $display("[FAIL] %0t: word got %h expected %h", $time, got, exp);
      end
   endtask

   // Compares a single flag.
   task automatic chk_bit(input logic got, input logic exp);
      totalChecks++;
      if (got !== exp) begin
         nFail++;
         $display("[FAIL] %0t: flag got %b expected %b", $time, got, exp);
      end
   endtask

   // One-cycle write strobe on the register port.
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk_sys);
      regAddr   <= a;
      regWrData <= {16'h0000, d};
      regWrite  <= 1'b1;
      @(posedge clk_sys);
      regWrite  <= 1'b0;
   endtask

   // One-cycle read strobe; data is taken in the following cycle only.
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk_sys);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge clk_sys);
      regRead <= 1'b0;
      #1;
      d = regRdData;
   endtask

   // Gives n rising edges on one oscillator input, then lets the pipeline settle.
   task automatic edges(input int n, input logic useExt);
      repeat (n) begin
         @(posedge clk_sys);
         if (useExt) begin
            externalOsc <= 1'b1;
         end else begin
            internalOsc <= 1'b1;
         end
         @(posedge clk_sys);
         externalOsc <= 1'b0;
         internalOsc <= 1'b0;
      end
      repeat (4) @(posedge clk_sys);
   endtask

   // Main sequence.
   initial begin
      {reset, regWrite, regRead, internalOsc, externalOsc, stopMode, standbyMode} = 7'b1000000;
      regAddr = '0;
      regWrData = '0;
      nFail = 0;
      totalChecks = 0;
      void'($urandom(32'hee573ae5));
      repeat (3) @(posedge clk_sys);
      reset <= 1'b0;
      // Reset values, unmapped and read-only places.
      rd(CTL_OFFSET, rdVal);
      chk_word(rdVal, 32'h0000_A000);
      rd(STAT_OFFSET, rdVal);
      chk_word(rdVal, 32'h0000_0FFF);
      wr(8'h08, 16'hFFFF);
      rd(8'h08, rdVal);
      chk_word(rdVal, 32'h0000_0000);
      wr(STAT_OFFSET, 16'h1234);
      rd(STAT_OFFSET, rdVal);
      chk_word(rdVal, 32'h0000_0FFF);
      rd(CTL_OFFSET, rdVal);
      chk_word(rdVal, 32'h0000_A000);
      // Random control words: fields store, key field always reads the pattern.
      repeat (12) begin
         rndWord = 16'($urandom);
         wr(CTL_OFFSET, rndWord);
         rd(CTL_OFFSET, rdVal);
         chk_word(rdVal, exp_ctrl(rndWord));
      end
      // Disabled watchdog holds its count while the oscillator runs.
      wr(CTL_OFFSET, 16'hA000);
      edges(16, 1'b0);
      rd(STAT_OFFSET, rdVal);
      chk_word(rdVal, 32'h0000_0FFF);
      // Every prescaler code: three counter ticks need three full divisions.
      for (int p = 0; p < 8; p++) begin
         wr(CTL_OFFSET, 16'hA100 | 16'(p));
         edges(3 << (p + 1), 1'b0);
         rd(STAT_OFFSET, rdVal);
         chk_word(rdVal, 32'h0000_0FFC);
      end
      // Clock source and freeze in each mode, standby and stop together too.
      foreach (MODE_CASES[i]) begin
         mc = MODE_CASES[i];
         @(posedge clk_sys);
         stopMode    <= mc[6];
         standbyMode <= mc[7];
         wr(CTL_OFFSET, 16'hA100 | {9'h000, mc[5:3], 4'h0});
         edges(4, mc[2]);
         rd(STAT_OFFSET, rdVal);
         chk_word(rdVal, 32'h0000_0FFF - 32'(mc[1:0]));
      end
      @(posedge clk_sys);
      stopMode    <= 1'b0;
      standbyMode <= 1'b0;
      // Refresh: a plain write leaves the count, the key reloads it.
      wr(CTL_OFFSET, 16'hA100);
      edges(6000, 1'b0);
      wr(CTL_OFFSET, 16'h0100);
      rd(STAT_OFFSET, rdVal);
      chk_word(rdVal, 32'h0000_0FFF - 32'd3000);
      wr(CTL_OFFSET, 16'hA100);
      rd(STAT_OFFSET, rdVal);
      chk_word(rdVal, 32'h0000_0FFF);
      // Expiry: one tick short of zero no reset, then reset at zero.
      edges(8188, 1'b0);
      rd(STAT_OFFSET, rdVal);
      chk_word(rdVal, 32'h0000_0001);
      chk_bit(watchdogReset, 1'b0);
      edges(2, 1'b0);
      for (int i = 0; i < 20 && watchdogReset !== 1'b1; i++) begin
         @(posedge clk_sys);
         #1;
      end
      chk_bit(watchdogReset, 1'b1);
      rd(STAT_OFFSET, rdVal);
      chk_word(rdVal, 32'h0000_1000);
      edges(4, 1'b0);
      chk_bit(watchdogReset, 1'b1);
      // A system reset clears the request, the control fields and the count.
      @(posedge clk_sys);
      reset <= 1'b1;
      repeat (3) @(posedge clk_sys);
      reset <= 1'b0;
      #1;
      chk_bit(watchdogReset, 1'b0);
      rd(CTL_OFFSET, rdVal);
      chk_word(rdVal, 32'h0000_A000);
      rd(STAT_OFFSET, rdVal);
      chk_word(rdVal, 32'h0000_0FFF);
      stop_test();
   end
endmodule
`default_nettype wire
